// ===== rtl/tcrb_bank.sv
// tile configuration register bank: decode, control registers, status outputs
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
module tcrb_bank #(
    parameter logic [7:0] CLOCK_BLOCK_COUNT = 8'h06,
    parameter logic [7:0] TIMER_COUNT = 8'h0a
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clk_en,
    // configuration access
    input wire logic cfg_req,
    input wire logic cfg_write,
    input wire tcrb_pkg::tcrb_source_type cfg_source,
    input wire logic [7:0] cfg_addr,
    input wire logic [31:0] cfg_wdata,
    output logic cfg_ack,
    output logic cfg_err,
    output logic [31:0] cfg_rdata,
    // processor status scratch view
    input wire logic ps_scratch_we,
    input wire logic [2:0] ps_scratch_addr,
    input wire logic [31:0] ps_scratch_wdata,
    output logic [31:0] ps_scratch_rdata,
    // core and OTP state
    input wire logic [31:0] core0_pc,
    input wire logic [31:0] core1_pc,
    input wire logic in_debug_flag,
    input wire logic [31:0] otp_security_word,
    input wire logic tile_divider_enable,
    // tile controls
    output logic debug_irq_request,
    output logic [15:0] clock_divide_value,
    output logic divided_clock_select,
    output logic tile_clock_stop,
    output logic security_write_lock,
    output logic global_debug_block,
    output logic otp_all_sector_lock,
    output logic [3:0] otp_per_sector_lock,
    output logic otp_redundancy_on,
    output logic boot_from_otp_override,
    output logic jtag_pll_boot_refuse,
    output logic core_debug_tap_block
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [1:0] guard_q, guard_d;
    logic irq_q, irq_d;
    logic [15:0] div_q, div_d;
    logic clk_off_q, clk_off_d;
    logic [31:0] sec_q, sec_d;
    logic ack_d, err_d;
    logic [31:0] rdata_d;
    logic locked;
    logic hit_scratch;
    logic scratch_we;
    logic [31:0] scratch_rdata;
    logic scratch_rd_q, scratch_rd_d;
    logic [31:0] rd_hold_q;
    logic dbg_sync1_q, dbg_sync2_q;
    logic [31:0] pc0_s1_q, pc0_s2_q, pc1_s1_q, pc1_s2_q;

    assign locked = guard_q[1] | guard_q[0];
    assign hit_scratch = (cfg_addr >= tcrb_pkg::OFF_SCRATCH_FIRST)
        && (cfg_addr <= tcrb_pkg::OFF_SCRATCH_LAST);
    assign scratch_we = cfg_req && cfg_write && hit_scratch && !locked;

    // ----------------------------------------------------------------
    // shared scratch storage
    // ----------------------------------------------------------------
    tcrb_scratch_mem #(
        .DEPTH(8),
        .AW(3)
    ) u_scratch (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .a_we(scratch_we),
        .a_addr(cfg_addr[2:0]),
        .a_wdata(cfg_wdata),
        .a_rdata(scratch_rdata),
        .b_we(ps_scratch_we && !locked),
        .b_addr(ps_scratch_addr),
        .b_wdata(ps_scratch_wdata),
        .b_rdata(ps_scratch_rdata)
    );

    // ----------------------------------------------------------------
    // decode and write
    // ----------------------------------------------------------------
    always_comb begin
        guard_d = guard_q;
        irq_d = irq_q;
        div_d = div_q;
        clk_off_d = clk_off_q;
        sec_d = otp_security_word & tcrb_pkg::SEC_MASK;
        ack_d = cfg_req;
        err_d = 1'b0;
        rdata_d = 32'h0000_0000;
        scratch_rd_d = 1'b0;
        if (cfg_req) begin
            if (cfg_addr == tcrb_pkg::OFF_RESOURCE_COUNTS) begin
                rdata_d[tcrb_pkg::CLKBLK_LSB +: 8] = CLOCK_BLOCK_COUNT;
                rdata_d[tcrb_pkg::TIMER_LSB +: 8] = TIMER_COUNT;
            end else if (cfg_addr == tcrb_pkg::OFF_DEBUG_WRITE_GUARD) begin
                rdata_d[tcrb_pkg::GUARD_HI_BIT] = guard_q[1];
                rdata_d[tcrb_pkg::GUARD_LO_BIT] = guard_q[0];
                // guard stays writable so it can lock itself; once set it
                // also freezes, which is the intended one-way lock
                if (cfg_write && !locked) begin
                    guard_d = {cfg_wdata[tcrb_pkg::GUARD_HI_BIT],
                        cfg_wdata[tcrb_pkg::GUARD_LO_BIT]};
                end
            end else if (cfg_addr == tcrb_pkg::OFF_DEBUG_INTERRUPT) begin
                rdata_d[tcrb_pkg::IRQ_REQ_BIT] = irq_q;
                rdata_d[tcrb_pkg::IN_DEBUG_BIT] = dbg_sync2_q;
                if (cfg_write && !locked) begin
                    irq_d = cfg_wdata[tcrb_pkg::IRQ_REQ_BIT];
                end
            end else if (cfg_addr == tcrb_pkg::OFF_CLOCK_DIVIDE) begin
                rdata_d[tcrb_pkg::CLK_OFF_BIT] = clk_off_q;
                rdata_d[tcrb_pkg::DIVIDER_WIDTH-1:0] = div_q;
                if (cfg_write && !locked) begin
                    div_d = cfg_wdata[tcrb_pkg::DIVIDER_WIDTH-1:0];
                    clk_off_d = cfg_wdata[tcrb_pkg::CLK_OFF_BIT];
                end
            end else if (cfg_addr == tcrb_pkg::OFF_SECURITY_COPY) begin
                // read-only copy; bit 31 leaves no write path anyway
                rdata_d = sec_q;
            end else if (hit_scratch) begin
                scratch_rd_d = 1'b1;
            end else if (cfg_addr == tcrb_pkg::OFF_CORE0_PC) begin
                rdata_d = pc0_s2_q;
            end else if (cfg_addr == tcrb_pkg::OFF_CORE1_PC) begin
                rdata_d = pc1_s2_q;
            end else begin
                err_d = 1'b1;
            end
            // irq clears once the core enters debug mode
        end
        if (dbg_sync2_q && !(cfg_req && cfg_write
                && cfg_addr == tcrb_pkg::OFF_DEBUG_INTERRUPT && !locked)) begin
            irq_d = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            guard_q <= tcrb_pkg::RST_GUARD;
            irq_q <= 1'b0;
            div_q <= tcrb_pkg::RST_DIVIDER;
            clk_off_q <= tcrb_pkg::RST_CLK_OFF;
            sec_q <= 32'h0000_0000;
            cfg_ack <= 1'b0;
            cfg_err <= 1'b0;
            rd_hold_q <= 32'h0000_0000;
            scratch_rd_q <= 1'b0;
            dbg_sync1_q <= 1'b0;
            dbg_sync2_q <= 1'b0;
            pc0_s1_q <= 32'h0000_0000;
            pc0_s2_q <= 32'h0000_0000;
            pc1_s1_q <= 32'h0000_0000;
            pc1_s2_q <= 32'h0000_0000;
        end else if (clk_en) begin
            guard_q <= guard_d;
            irq_q <= irq_d;
            div_q <= div_d;
            clk_off_q <= clk_off_d;
            sec_q <= sec_d;
            cfg_ack <= ack_d;
            cfg_err <= err_d;
            rd_hold_q <= rdata_d;
            scratch_rd_q <= scratch_rd_d;
            // core state arrives from other clock domains; two flops each, the OTP word is registered once above
            dbg_sync1_q <= in_debug_flag;
            dbg_sync2_q <= dbg_sync1_q;
            pc0_s1_q <= core0_pc;
            pc0_s2_q <= pc0_s1_q;
            pc1_s1_q <= core1_pc;
            pc1_s2_q <= pc1_s1_q;
        end
    end

    assign cfg_rdata = scratch_rd_q ? scratch_rdata : rd_hold_q;

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign debug_irq_request = irq_q;
    assign clock_divide_value = div_q;
    assign divided_clock_select = tile_divider_enable;
    assign tile_clock_stop = clk_off_q;
    assign security_write_lock = sec_q[tcrb_pkg::SEC_WRITE_LOCK_BIT];
    assign global_debug_block = sec_q[tcrb_pkg::SEC_GLOBAL_DEBUG_BIT];
    assign otp_all_sector_lock = sec_q[tcrb_pkg::SEC_OTP_ALL_LOCK_BIT];
    assign otp_per_sector_lock = sec_q[tcrb_pkg::SEC_OTP_SECTOR_LSB +: 4]
        | {4{sec_q[tcrb_pkg::SEC_OTP_ALL_LOCK_BIT]}};
    assign otp_redundancy_on = sec_q[tcrb_pkg::SEC_OTP_REDUNDANCY_BIT];
    assign boot_from_otp_override = sec_q[tcrb_pkg::SEC_BOOT_OTP_BIT];
    assign jtag_pll_boot_refuse = sec_q[tcrb_pkg::SEC_JTAG_CFG_BIT];
    assign core_debug_tap_block = sec_q[tcrb_pkg::SEC_TAP_BLOCK_BIT];

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    AST_RESOURCE_READ: assert property (
        clk_en && cfg_req && !cfg_write && cfg_addr == tcrb_pkg::OFF_RESOURCE_COUNTS
        |=> cfg_ack && cfg_rdata == {16'h0000, CLOCK_BLOCK_COUNT, TIMER_COUNT})
        else $error("resource count read wrong");
    AST_GUARD_BLOCKS_DIV: assert property (
        clk_en && locked |=> $stable(div_q) && $stable(clk_off_q))
        else $error("divider written while guarded");
    AST_GUARD_BLOCKS_SCRATCH: assert property (
        locked |-> !scratch_we)
        else $error("scratch written while guarded");
    AST_IRQ_SET: assert property (
        clk_en && !locked && cfg_req && cfg_write
        && cfg_addr == tcrb_pkg::OFF_DEBUG_INTERRUPT && cfg_wdata[0]
        |=> debug_irq_request)
        else $error("debug request not raised");
    AST_IN_DEBUG_READ: assert property (
        clk_en && cfg_req && cfg_addr == tcrb_pkg::OFF_DEBUG_INTERRUPT
        |=> cfg_rdata[1] == $past(dbg_sync2_q))
        else $error("debug mode bit wrong");
    AST_DIV_WRITE: assert property (
        clk_en && !locked && cfg_req && cfg_write && cfg_addr == tcrb_pkg::OFF_CLOCK_DIVIDE
        |=> clock_divide_value == $past(cfg_wdata[15:0])
        && tile_clock_stop == $past(cfg_wdata[31]))
        else $error("divider write lost");
    AST_SEC_RESERVED_ZERO: assert property (
        (sec_q & ~tcrb_pkg::SEC_MASK) == 32'h0000_0000)
        else $error("reserved security bit set");
    AST_UNMAPPED_ERR: assert property (
        clk_en && cfg_req && cfg_addr == 8'h03 |=> cfg_err && cfg_rdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    AST_SCRATCH_SHARED: assert property (
        clk_en && ps_scratch_we && !locked && !scratch_we ##1 clk_en && cfg_req
        && !cfg_write && cfg_addr == {5'b00100, $past(ps_scratch_addr)}
        |=> cfg_rdata == $past(ps_scratch_wdata, 2))
        else $error("scratch views differ");
    AST_GUARD_SELF_LOCK: assert property (
        clk_en && locked |=> $stable(guard_q))
        else $error("guard changed while set");
    AST_GUARD_BLOCKS_IRQ: assert property (
        clk_en && locked && !irq_q |=> !debug_irq_request)
        else $error("debug request raised while guarded");
    AST_IRQ_DEBUG_CLEAR: assert property (
        clk_en && dbg_sync2_q && !(cfg_req && cfg_write)
        |=> !debug_irq_request)
        else $error("debug request held in debug mode");
    AST_SEC_COPY: assert property (
        clk_en |=> sec_q == ($past(otp_security_word) & tcrb_pkg::SEC_MASK))
        else $error("security copy stale");
    AST_PC_READ: assert property (
        clk_en && cfg_req && cfg_addr == tcrb_pkg::OFF_CORE1_PC
        |=> cfg_rdata == $past(pc1_s2_q))
        else $error("program counter read wrong");
    AST_RO_WRITE_ACKED: assert property (
        clk_en && cfg_req && cfg_write && cfg_addr == tcrb_pkg::OFF_SECURITY_COPY
        |=> cfg_ack && !cfg_err)
        else $error("read-only write refused");
    // frozen state must not take an update on any edge while the enable is low
    AST_FROZEN: assert property (
        !clk_en |=> $stable(sec_q) && $stable(guard_q) && $stable(div_q)
        && $stable(irq_q) && $stable(cfg_ack))
        else $error("state moved while clock enable low");

    COV_GUARD_SET: cover property (guard_q != 2'h0);
    COV_IRQ: cover property (debug_irq_request);
    COV_SCRATCH_RD: cover property (scratch_rd_q);
    COV_CLOCK_STOP: cover property (tile_clock_stop);
    COV_DEBUG_CLEAR: cover property (dbg_sync2_q && irq_q);
endmodule : tcrb_bank
`default_nettype wire

// ===== rtl/tcrb_pkg.sv
// tile configuration register bank: shared offsets, fields and reset values
package tcrb_pkg;
    // ----------------------------------------------------------------
    // register numbers
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_RESOURCE_COUNTS = 8'h02;
    localparam logic [7:0] OFF_DEBUG_WRITE_GUARD = 8'h04;
    localparam logic [7:0] OFF_DEBUG_INTERRUPT = 8'h05;
    localparam logic [7:0] OFF_CLOCK_DIVIDE = 8'h06;
    localparam logic [7:0] OFF_SECURITY_COPY = 8'h07;
    localparam logic [7:0] OFF_SCRATCH_FIRST = 8'h20;
    localparam logic [7:0] OFF_SCRATCH_LAST = 8'h27;
    localparam logic [7:0] OFF_CORE0_PC = 8'h40;
    localparam logic [7:0] OFF_CORE1_PC = 8'h41;
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CLKBLK_LSB = 8;
    localparam int TIMER_LSB = 0;
    localparam int GUARD_HI_BIT = 31;
    localparam int GUARD_LO_BIT = 0;
    localparam int IRQ_REQ_BIT = 0;
    localparam int IN_DEBUG_BIT = 1;
    localparam int CLK_OFF_BIT = 31;
    localparam int DIVIDER_WIDTH = 16;
    localparam int SEC_WRITE_LOCK_BIT = 31;
    localparam int SEC_GLOBAL_DEBUG_BIT = 14;
    localparam int SEC_OTP_ALL_LOCK_BIT = 12;
    localparam int SEC_OTP_SECTOR_LSB = 8;
    localparam int SEC_OTP_REDUNDANCY_BIT = 7;
    localparam int SEC_BOOT_OTP_BIT = 5;
    localparam int SEC_JTAG_CFG_BIT = 4;
    localparam int SEC_TAP_BLOCK_BIT = 0;
    // implemented bits of the security word; the rest read as zero
    localparam logic [31:0] SEC_MASK = 32'h8000_5fb1;
    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [1:0] RST_GUARD = 2'h0;
    localparam logic [1:0] RST_DEBUG_INT = 2'h0;
    localparam logic [15:0] RST_DIVIDER = 16'h0000;
    localparam logic RST_CLK_OFF = 1'b0;
    localparam logic [31:0] RST_SCRATCH = 32'h0000_0000;
    // accessor that issued a configuration access
    typedef enum logic [1:0] {
        SRC_TILE_SWITCH,
        SRC_SYSTEM_SWITCH,
        SRC_CORE_SCRATCH,
        SRC_JTAG
    } tcrb_source_type;
endpackage : tcrb_pkg

// ===== rtl/tcrb_scratch_mem.sv
// tcrb scratch store: two write ports, two registered read ports
`timescale 1ns/1ns
`default_nettype none
module tcrb_scratch_mem #(
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clk_en,
    // configuration port
    input wire logic a_we,
    input wire logic [AW-1:0] a_addr,
    input wire logic [31:0] a_wdata,
    output logic [31:0] a_rdata,
    // processor status port
    input wire logic b_we,
    input wire logic [AW-1:0] b_addr,
    input wire logic [31:0] b_wdata,
    output logic [31:0] b_rdata
);
    logic [31:0] mem_q [DEPTH];
    logic [31:0] mem_d [DEPTH];
    logic [31:0] a_rdata_d;
    logic [31:0] b_rdata_d;

    // one storage behind both views; port b wins a same-word collision
    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            mem_d[i] = mem_q[i];
        end
        if (a_we) begin
            mem_d[a_addr] = a_wdata;
        end
        if (b_we) begin
            mem_d[b_addr] = b_wdata;
        end
        a_rdata_d = mem_d[a_addr];
        b_rdata_d = mem_d[b_addr];
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= tcrb_pkg::RST_SCRATCH;
            end
            a_rdata <= 32'h0000_0000;
            b_rdata <= 32'h0000_0000;
        end else if (clk_en) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= mem_d[i];
            end
            a_rdata <= a_rdata_d;
            b_rdata <= b_rdata_d;
        end
    end
endmodule : tcrb_scratch_mem
`default_nettype wire

// ===== test/tcrb_cfg_master.sv
// tcrb configuration master model: single-cycle configuration reads and writes
`timescale 1ns/1ns
`default_nettype none
module tcrb_cfg_master (
    // clock
    input wire logic sys_clk,
    // request side
    output logic cfg_req,
    output logic cfg_write,
    output tcrb_pkg::tcrb_source_type cfg_source,
    output logic [7:0] cfg_addr,
    output logic [31:0] cfg_wdata,
    // answer side
    input wire logic cfg_ack,
    input wire logic cfg_err,
    input wire logic [31:0] cfg_rdata
);
    initial begin
        cfg_req = 1'b0;
        cfg_write = 1'b0;
        cfg_source = tcrb_pkg::SRC_TILE_SWITCH;
        cfg_addr = 8'h00;
        cfg_wdata = 32'h0000_0000;
    end
    // ----------------------------------------------------------------
    // access by register number only; the debugger's scratch exchange rides on it
    // ----------------------------------------------------------------
    task automatic access(input logic wr, input tcrb_pkg::tcrb_source_type src,
        input logic [7:0] a, input logic [31:0] d, input int gap,
        output logic [31:0] rd, output logic er, output logic ok);
        int n;
        repeat (gap) @(posedge sys_clk);
        @(posedge sys_clk);
        cfg_req <= 1'b1;
        cfg_write <= wr;
        cfg_source <= src;
        cfg_addr <= a;
        cfg_wdata <= d;
        @(posedge sys_clk);
        // idle qualifiers flip so a stale value never looks valid
        cfg_req <= 1'b0;
        cfg_write <= ~wr;
        cfg_addr <= ~a;
        cfg_wdata <= ~d;
        ok = 1'b0;
        rd = 32'h0;
        er = 1'b0;
        n = 0;
        while (!ok && n < 4) begin
            #1;
            if (cfg_ack === 1'b1) begin
                ok = 1'b1;
                rd = cfg_rdata;
                er = cfg_err;
            end else begin
                @(posedge sys_clk);
            end
            n++;
        end
    endtask : access
endmodule : tcrb_cfg_master
`default_nettype wire

// ===== test/tile_config_register_bank_bench.sv
// tcrb self-checking bench: row table then hand-written guard, irq and security tests
`timescale 1ns/1ns
`default_nettype none
module tile_config_register_bank_bench;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    localparam logic [7:0] NCLK = 8'h05;
    localparam logic [7:0] NTMR = 8'h0c;
    localparam logic [31:0] PC0 = 32'h0001_0a40;
    localparam logic [31:0] PC1 = 32'h0002_0b41;
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [31:0] wd;
        logic [31:0] exp;
        logic err;
    } tcrb_row_type;
    tcrb_row_type rows [19] = '{
        '{1'b0, 8'h02, 32'h0, {16'h0, NCLK, NTMR}, 1'b0},
        '{1'b1, 8'h02, 32'hffff_ffff, 32'h0, 1'b0},
        '{1'b0, 8'h02, 32'h0, {16'h0, NCLK, NTMR}, 1'b0}, '{1'b0, 8'h04, 32'h0, 32'h0, 1'b0},
        '{1'b0, 8'h05, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h06, 32'h0, 32'h0, 1'b0},
        '{1'b1, 8'h06, 32'h7fff_1234, 32'h0, 1'b0}, '{1'b0, 8'h06, 32'h0, 32'h0000_1234, 1'b0},
        '{1'b1, 8'h20, 32'hdead_beef, 32'h0, 1'b0}, '{1'b1, 8'h27, 32'h0bad_f00d, 32'h0, 1'b0},
        '{1'b0, 8'h20, 32'h0, 32'hdead_beef, 1'b0}, '{1'b0, 8'h27, 32'h0, 32'h0bad_f00d, 1'b0},
        '{1'b1, 8'h40, 32'hffff_ffff, 32'h0, 1'b0}, '{1'b0, 8'h40, 32'h0, PC0, 1'b0},
        '{1'b0, 8'h41, 32'h0, PC1, 1'b0}, '{1'b1, 8'h07, 32'h0, 32'h0, 1'b0},
        '{1'b0, 8'h07, 32'h0, 32'h8000_5fb1, 1'b0}, '{1'b0, 8'h03, 32'h0, 32'h0, 1'b1},
        '{1'b0, 8'h28, 32'h0, 32'h0, 1'b1}};
    logic [31:0] sec [3] = '{32'h8000_4a21, 32'h0000_1590, 32'h0};
    logic [31:0] gv [2] = '{32'hffff_ffff, 32'h8000_0000};
    logic [7:0] ga [4] = '{8'h04, 8'h05, 8'h06, 8'h20};
    logic sys_clk = 1'b0, nrst = 1'b0, clk_en = 1'b1, in_debug_flag = 1'b0;
    logic tile_divider_enable = 1'b0, ps_scratch_we = 1'b0, er;
    logic [2:0] ps_scratch_addr = 3'h0;
    logic [31:0] ps_scratch_wdata = 32'h0, otp_security_word = 32'hffff_ffff, rd;
    logic [31:0] core0_pc = PC0, core1_pc = PC1, cfg_wdata, cfg_rdata, ps_scratch_rdata;
    logic cfg_req, cfg_write, cfg_ack, cfg_err, debug_irq_request, divided_clock_select;
    logic tile_clock_stop, security_write_lock, global_debug_block, otp_all_sector_lock;
    logic otp_redundancy_on, boot_from_otp_override, jtag_pll_boot_refuse, core_debug_tap_block;
    logic [3:0] otp_per_sector_lock;
    logic [7:0] cfg_addr;
    logic [15:0] clock_divide_value;
    tcrb_pkg::tcrb_source_type cfg_source, src = tcrb_pkg::SRC_TILE_SWITCH;
    int err_count = 0, checks = 0, cycles = 0;
    always #20 sys_clk = ~sys_clk;
    // ----------------------------------------------------------------
    // design and master
    // ----------------------------------------------------------------
    tcrb_bank #(.CLOCK_BLOCK_COUNT(NCLK), .TIMER_COUNT(NTMR)) DUT (.sys_clk(sys_clk),
        .nrst(nrst), .clk_en(clk_en), .cfg_req(cfg_req), .cfg_write(cfg_write),
        .cfg_source(cfg_source), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
        .cfg_ack(cfg_ack), .cfg_err(cfg_err), .cfg_rdata(cfg_rdata),
        .ps_scratch_we(ps_scratch_we), .ps_scratch_addr(ps_scratch_addr),
        .ps_scratch_wdata(ps_scratch_wdata), .ps_scratch_rdata(ps_scratch_rdata),
        .core0_pc(core0_pc), .core1_pc(core1_pc), .in_debug_flag(in_debug_flag),
        .otp_security_word(otp_security_word), .tile_divider_enable(tile_divider_enable),
        .debug_irq_request(debug_irq_request), .clock_divide_value(clock_divide_value),
        .divided_clock_select(divided_clock_select), .tile_clock_stop(tile_clock_stop),
        .security_write_lock(security_write_lock), .global_debug_block(global_debug_block),
        .otp_all_sector_lock(otp_all_sector_lock), .otp_per_sector_lock(otp_per_sector_lock),
        .otp_redundancy_on(otp_redundancy_on), .boot_from_otp_override(boot_from_otp_override),
        .jtag_pll_boot_refuse(jtag_pll_boot_refuse), .core_debug_tap_block(core_debug_tap_block));
    tcrb_cfg_master m (.sys_clk(sys_clk), .cfg_req(cfg_req), .cfg_write(cfg_write),
        .cfg_source(cfg_source), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
        .cfg_ack(cfg_ack), .cfg_err(cfg_err), .cfg_rdata(cfg_rdata));
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask : check
    task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d, input int gap);
        logic ok;
        m.access(wr, src, a, d, gap, rd, er, ok);
        check("cfg_ack", {31'h0, ok}, 32'h1);
    endtask : acc
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0, 0);
        check("cfg_rdata", rd, e);
    endtask : rd_chk
    // processor status scratch view; read data settles one cycle after the address
    task automatic ps(input logic we, input logic [2:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        ps_scratch_we <= we;
        ps_scratch_addr <= a;
        ps_scratch_wdata <= d;
        @(posedge sys_clk);
        ps_scratch_we <= 1'b0;
        ps_scratch_wdata <= ~d;
        @(posedge sys_clk);
        #1;
    endtask : ps
    task automatic end_sim;
        if (err_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim
    // cut a hang short well above the few hundred cycles the run needs
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            err_count++;
            end_sim();
        end
    end
    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        for (int i = 0; i < 19; i++) begin
            src = tcrb_pkg::tcrb_source_type'(i % 4);
            acc(rows[i].wr, rows[i].addr, rows[i].wd, i % 3);
            check("cfg_err", {31'h0, er}, {31'h0, rows[i].err});
            if (!rows[i].wr) begin
                check("row", rd, rows[i].exp);
            end
        end
        acc(1'b1, 8'h06, 32'h8000_0005, 0);
        check("divider", {16'h0, clock_divide_value}, 32'h5);
        check("clock_stop", {31'h0, tile_clock_stop}, 32'h1);
        rd_chk(8'h06, 32'h8000_0005);
        for (int e = 0; e < 2; e++) begin
            tile_divider_enable <= e[0];
            @(posedge sys_clk);
            #1;
            check("select", {31'h0, divided_clock_select}, {31'h0, e[0]});
        end
        acc(1'b1, 8'h05, 32'h1, 0);
        check("irq", {31'h0, debug_irq_request}, 32'h1);
        acc(1'b1, 8'h05, 32'h0, 1);
        check("irq", {31'h0, debug_irq_request}, 32'h0);
        acc(1'b1, 8'h05, 32'h1, 0);
        check("irq", {31'h0, debug_irq_request}, 32'h1);
        in_debug_flag <= 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        check("irq_debug", {31'h0, debug_irq_request}, 32'h0);
        rd_chk(8'h05, 32'h2);
        in_debug_flag <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rd_chk(8'h05, 32'h0);
        foreach (sec[k]) begin
            otp_security_word <= sec[k];
            repeat (4) @(posedge sys_clk);
            rd_chk(8'h07, sec[k] & tcrb_pkg::SEC_MASK);
            check("sec_out", {21'h0, security_write_lock,
                global_debug_block, otp_all_sector_lock, otp_per_sector_lock,
                otp_redundancy_on, boot_from_otp_override, jtag_pll_boot_refuse,
                core_debug_tap_block},
                {21'h0, sec[k][31], sec[k][14], sec[k][12], sec[k][11:8] | {4{sec[k][12]}},
                sec[k][7], sec[k][5], sec[k][4], sec[k][0]});
        end
        // a low enable must hold the copy even while the word underneath moves
        clk_en <= 1'b0;
        otp_security_word <= 32'h0000_0001;
        repeat (3) @(posedge sys_clk);
        #1;
        check("frozen", {31'h0, core_debug_tap_block}, 32'h0);
        clk_en <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        check("thawed", {31'h0, core_debug_tap_block}, 32'h1);
        ps(1'b1, 3'h3, 32'h1357_9bdf);
        rd_chk(8'h23, 32'h1357_9bdf);
        acc(1'b1, 8'h21, 32'h2468_ace0, 2);
        ps(1'b0, 3'h1, 32'h0);
        check("ps_scratch", ps_scratch_rdata, 32'h2468_ace0);
        // status-side write then a configuration read of that word on the next cycle
        fork
            ps(1'b1, 3'h5, 32'h0f0f_0f0f);
            acc(1'b0, 8'h25, 32'h0, 1);
        join
        check("cfg_rdata", rd, 32'h0f0f_0f0f);
        // the guard set with both bits, then with bit 31 alone, locks every writable register, itself included
        for (int g = 0; g < 2; g++) begin
            @(posedge sys_clk);
            nrst <= 1'b0;
            repeat (4) @(posedge sys_clk);
            nrst <= 1'b1;
            acc(1'b1, 8'h04, gv[g], 0);
            rd_chk(8'h04, gv[g] & 32'h8000_0001);
            for (int s = 0; s < 4; s++) begin
                src = tcrb_pkg::tcrb_source_type'(s);
                acc(1'b1, ga[s], (s == 0) ? 32'h0 : 32'hffff_ffff, s % 2);
            end
            ps(1'b1, 3'h0, 32'hffff_ffff);
            rd_chk(8'h04, gv[g] & 32'h8000_0001);
            for (int s = 1; s < 4; s++) rd_chk(ga[s], 32'h0);
            check("irq", {31'h0, debug_irq_request}, 32'h0);
        end
        end_sim();
    end
endmodule : tile_config_register_bank_bench
`default_nettype wire
